// >>> src/cau_pkg.sv
// Constants and types shared by the complex add unit
package cau_pkg;

   // ---------------------------------------------------------------
   // Data widths
   // ---------------------------------------------------------------
   localparam int CAU_DATA_W = 32;
   localparam int CAU_INSTR_W = 16;
   localparam int CAU_SHIFT_W = 5;
   localparam int CAU_ADDR_W = 8;
   localparam int CAU_NUM_REGS = 9;
   localparam int CAU_NUM_EVENTS = 3;

   // ---------------------------------------------------------------
   // Instruction encodings
   // ---------------------------------------------------------------
   localparam logic [15:0] CAU_OPC_ADD_BASE = 16'hE502;
   localparam logic [15:0] CAU_OPC_ADD_LOAD = 16'hE3F8;
   localparam logic [15:0] CAU_OPC_ADD_ALT = 16'hE52A;
   localparam logic [10:0] CAU_OPC_SET_SHR = 11'h72A;
   localparam int CAU_SET_SHR_POS = 5;
   localparam int CAU_LOAD_IDX_LSB = 8;
   localparam int CAU_LOAD_TAG_LSB = 12;

   // ---------------------------------------------------------------
   // Working register indices
   // ---------------------------------------------------------------
   localparam logic [3:0] CAU_R2 = 4'h2;
   localparam logic [3:0] CAU_R3 = 4'h3;
   localparam logic [3:0] CAU_R4 = 4'h4;
   localparam logic [3:0] CAU_R5 = 4'h5;
   localparam logic [3:0] CAU_R6 = 4'h6;
   localparam logic [3:0] CAU_R7 = 4'h7;
   localparam logic [3:0] CAU_R8 = 4'h8;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CAU_ADR_STATUS = 8'h00;
   localparam logic [7:0] CAU_ADR_INT_STAT = 8'h04;
   localparam logic [7:0] CAU_ADR_INT_MASK = 8'h08;
   localparam logic [7:0] CAU_ADR_WORK_BASE = 8'h40;
   localparam logic [7:0] CAU_ADR_WORK_LAST = 8'h60;

   // Status word field positions
   localparam int CAU_ST_SHIFT_LSB = 0;
   localparam int CAU_ST_RND = 8;
   localparam int CAU_ST_SAT = 9;
   localparam int CAU_ST_REAL_OVERFLOW_FLAG = 16;
   localparam int CAU_ST_IMAG_OVERFLOW_FLAG = 17;

   // Interrupt event bit positions
   localparam int CAU_EV_REAL_OVERFLOW_FLAG = 0;
   localparam int CAU_EV_IMAG_OVERFLOW_FLAG = 1;
   localparam int CAU_EV_DONE = 2;

   // Reset values
   localparam logic [31:0] CAU_RST_WORK = 32'h0000_0000;
   localparam logic [4:0] CAU_RST_SHIFT = 5'h00;
   localparam logic CAU_RST_RND = 1'b0;
   localparam logic CAU_RST_SAT = 1'b0;
   localparam logic [2:0] CAU_RST_MASK = 3'h0;

   // Saturation limits
   localparam logic [31:0] CAU_MAX_POS = 32'h7FFF_FFFF;
   localparam logic [31:0] CAU_MAX_NEG = 32'h8000_0000;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_ADD_BASE,
      OP_ADD_LOAD,
      OP_ADD_ALT,
      OP_SET_SHR
   } cau_op_e;

endpackage

// >>> src/cau_complex_add.sv
// Complex 32-bit add datapath with Wishbone register access
`timescale 1ns/1ps

// Function
// - Operands: 32-bit signed real and imaginary registers
// - Base add: r5,r4 plus shifted r3,r2
// - Base add opcode E502 single word
// - Second operand arithmetic right shift by amount
// - Round discarded bits when enabled, else truncate
// - Saturate each part when enabled, else wrap
// - Real overflow sets real flag only
// - Imaginary overflow sets imaginary flag only
// - Base add finishes in one cycle
// - Add-with-load: E3F8 plus index word
// - Load memory word into chosen register concurrently
// - Add and load each take one cycle
// - Alt add: r7,r6 plus shifted r5,r4
// - Alt add opcode E52A single word
// - Alt add real overflow sets real flag
// - Shift amount unsigned 5-bit, set by instruction
module cau_complex_add
   import cau_pkg::*;
#(
   parameter int NUM_REGS = CAU_NUM_REGS
)
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic instr_valid_i,
   input wire logic [CAU_INSTR_W-1:0] first_instruction_word_i,
   input wire logic [CAU_INSTR_W-1:0] second_instruction_word_i,
   input wire logic [CAU_DATA_W-1:0] memory_word_operand_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [CAU_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [CAU_DATA_W-1:0] wb_dat_i,
   output logic [CAU_DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic op_done_o,
   output logic irq_o
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [NUM_REGS-1:0][CAU_DATA_W-1:0] work;
      logic [CAU_SHIFT_W-1:0] shift;
      logic rnd;
      logic sat;
      logic real_overflow_flag;
      logic imag_overflow_flag;
      logic [CAU_NUM_EVENTS-1:0] int_stat;
      logic [CAU_NUM_EVENTS-1:0] int_mask;
      logic ack;
      logic [CAU_DATA_W-1:0] rdata;
      logic done;
   } cau_state_s;

   cau_state_s state_ff;
   cau_state_s nxt_state;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic cau_op_e cau_decode(input logic [15:0] w);
      cau_op_e op;
      op = OP_NONE;
      if (w == CAU_OPC_ADD_BASE)
      begin
         op = OP_ADD_BASE;
      end
      else if (w == CAU_OPC_ADD_LOAD)
      begin
         op = OP_ADD_LOAD;
      end
      else if (w == CAU_OPC_ADD_ALT)
      begin
         op = OP_ADD_ALT;
      end
      else if (w[15:CAU_SET_SHR_POS] == CAU_OPC_SET_SHR)
      begin
         op = OP_SET_SHR;
      end
      return op;
   endfunction

   // Arithmetic shift of one part with optional rounding
   function automatic logic [31:0] cau_shift_round(
      input logic [31:0] v,
      input logic [4:0] amt,
      input logic rnd
   );
      logic [31:0] shifted;
      logic [31:0] half;
      shifted = $unsigned($signed(v) >>> amt);
      half = 32'h0000_0000;
      // A shift of zero discards nothing, so nothing to round
      if (rnd && (amt != 5'h00))
      begin
         half = {31'h0000_0000, v[amt - 5'h01]};
      end
      // Cannot carry out: any nonzero shift leaves headroom
      return shifted + half;
   endfunction

   // Returns {overflow, result} for one 32-bit part
   function automatic logic [32:0] cau_add_part(
      input logic [31:0] a,
      input logic [31:0] b,
      input logic sat
   );
      logic [32:0] sum;
      logic ovf;
      logic [31:0] res;
      sum = {a[31], a} + {b[31], b};
      ovf = sum[32] ^ sum[31];
      res = sum[31:0];
      if (ovf && sat)
      begin
         res = sum[32] ? CAU_MAX_NEG : CAU_MAX_POS;
      end
      return {ovf, res};
   endfunction

   // Byte-lane merge for Wishbone writes
   function automatic logic [31:0] cau_merge(
      input logic [31:0] old,
      input logic [31:0] dat,
      input logic [3:0] sel
   );
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            m[i*8 +: 8] = dat[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // ---------------------------------------------------------------
   // Datapath
   // ---------------------------------------------------------------
   cau_op_e op;
   logic [31:0] x_re;
   logic [31:0] x_im;
   logic [31:0] y_re;
   logic [31:0] y_im;
   logic [32:0] sum_re;
   logic [32:0] sum_im;
   logic [3:0] load_idx;
   logic [31:0] status_word;
   logic [NUM_REGS-1:0] work_hit;
   logic bus_req;
   logic bus_wr;

   always_comb
   begin
      op = instr_valid_i ? cau_decode(first_instruction_word_i) : OP_NONE;
      // The alt form reads r7..r4; every other form reads r5..r2
      if (op == OP_ADD_ALT)
      begin
         x_re = state_ff.work[CAU_R7];
         x_im = state_ff.work[CAU_R6];
         y_re = state_ff.work[CAU_R5];
         y_im = state_ff.work[CAU_R4];
      end
      else
      begin
         x_re = state_ff.work[CAU_R5];
         x_im = state_ff.work[CAU_R4];
         y_re = state_ff.work[CAU_R3];
         y_im = state_ff.work[CAU_R2];
      end
      sum_re = cau_add_part(x_re,
         cau_shift_round(y_re, state_ff.shift, state_ff.rnd), state_ff.sat);
      sum_im = cau_add_part(x_im,
         cau_shift_round(y_im, state_ff.shift, state_ff.rnd), state_ff.sat);
      load_idx = second_instruction_word_i[CAU_LOAD_IDX_LSB +: 4];
   end

   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[CAU_ST_SHIFT_LSB +: CAU_SHIFT_W] = state_ff.shift;
      status_word[CAU_ST_RND] = state_ff.rnd;
      status_word[CAU_ST_SAT] = state_ff.sat;
      status_word[CAU_ST_REAL_OVERFLOW_FLAG] = state_ff.real_overflow_flag;
      status_word[CAU_ST_IMAG_OVERFLOW_FLAG] = state_ff.imag_overflow_flag;
   end

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g++)
      begin : g_hit
         assign work_hit[g] =
            (wb_adr_i == CAU_ADR_WORK_BASE + 8'(g * 4));
      end
   endgenerate

   assign bus_req = wb_cyc_i && wb_stb_i;
   // Writes land on the edge where the master sees ack
   assign bus_wr = bus_req && wb_we_i && state_ff.ack;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [CAU_NUM_EVENTS-1:0] events;
      logic [CAU_NUM_EVENTS-1:0] clr;
      logic [31:0] st_new;
      events = '0;
      clr = '0;
      st_new = 32'h0000_0000;
      nxt_state = state_ff;
      nxt_state.done = 1'b0;

      // Register access: ack one cycle after the request, then drop
      nxt_state.ack = bus_req && !state_ff.ack;
      if (bus_req && !state_ff.ack)
      begin
         nxt_state.rdata = 32'h0000_0000;
         if (wb_adr_i == CAU_ADR_STATUS)
         begin
            nxt_state.rdata = status_word;
         end
         else if (wb_adr_i == CAU_ADR_INT_STAT)
         begin
            nxt_state.rdata = 32'(state_ff.int_stat);
         end
         else if (wb_adr_i == CAU_ADR_INT_MASK)
         begin
            nxt_state.rdata = 32'(state_ff.int_mask);
         end
         for (int i = 0; i < NUM_REGS; i++)
         begin
            if (work_hit[i])
            begin
               nxt_state.rdata = state_ff.work[i];
            end
         end
      end

      if (bus_wr)
      begin
         if (wb_adr_i == CAU_ADR_STATUS)
         begin
            st_new = cau_merge(status_word, wb_dat_i, wb_sel_i);
            nxt_state.shift = st_new[CAU_ST_SHIFT_LSB +: CAU_SHIFT_W];
            nxt_state.rnd = st_new[CAU_ST_RND];
            nxt_state.sat = st_new[CAU_ST_SAT];
            // Flags only drop on an explicit write of one
            if (wb_sel_i[CAU_ST_REAL_OVERFLOW_FLAG / 8] && wb_dat_i[CAU_ST_REAL_OVERFLOW_FLAG])
            begin
               nxt_state.real_overflow_flag = 1'b0;
            end
            if (wb_sel_i[CAU_ST_IMAG_OVERFLOW_FLAG / 8] && wb_dat_i[CAU_ST_IMAG_OVERFLOW_FLAG])
            begin
               nxt_state.imag_overflow_flag = 1'b0;
            end
         end
         else if (wb_adr_i == CAU_ADR_INT_STAT && wb_sel_i[0])
         begin
            clr = wb_dat_i[CAU_NUM_EVENTS-1:0];
         end
         else if (wb_adr_i == CAU_ADR_INT_MASK && wb_sel_i[0])
         begin
            nxt_state.int_mask = wb_dat_i[CAU_NUM_EVENTS-1:0];
         end
         for (int i = 0; i < NUM_REGS; i++)
         begin
            if (work_hit[i])
            begin
               nxt_state.work[i] =
                  cau_merge(state_ff.work[i], wb_dat_i, wb_sel_i);
            end
         end
      end

      // Instructions override a bus write in the same cycle
      unique case (op)
         OP_NONE:
         begin
         end
         OP_SET_SHR:
         begin
            nxt_state.shift =
               first_instruction_word_i[CAU_SHIFT_W-1:0];
            nxt_state.done = 1'b1;
         end
         OP_ADD_BASE, OP_ADD_LOAD:
         begin
            // Load first so that a forbidden r5/r4 target
            // still leaves the sum in place
            if (op == OP_ADD_LOAD && load_idx < 4'(NUM_REGS))
            begin
               nxt_state.work[load_idx] = memory_word_operand_i;
            end
            nxt_state.work[CAU_R5] = sum_re[31:0];
            nxt_state.work[CAU_R4] = sum_im[31:0];
            events[CAU_EV_REAL_OVERFLOW_FLAG] = sum_re[32];
            events[CAU_EV_IMAG_OVERFLOW_FLAG] = sum_im[32];
            nxt_state.done = 1'b1;
         end
         OP_ADD_ALT:
         begin
            nxt_state.work[CAU_R7] = sum_re[31:0];
            nxt_state.work[CAU_R6] = sum_im[31:0];
            events[CAU_EV_REAL_OVERFLOW_FLAG] = sum_re[32];
            events[CAU_EV_IMAG_OVERFLOW_FLAG] = sum_im[32];
            nxt_state.done = 1'b1;
         end
      endcase

      // A set in the same cycle as a clear wins
      if (events[CAU_EV_REAL_OVERFLOW_FLAG])
      begin
         nxt_state.real_overflow_flag = 1'b1;
      end
      if (events[CAU_EV_IMAG_OVERFLOW_FLAG])
      begin
         nxt_state.imag_overflow_flag = 1'b1;
      end
      events[CAU_EV_DONE] = nxt_state.done;
      nxt_state.int_stat = (state_ff.int_stat & ~clr) | events;
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state_ff <= '0;
         for (int i = 0; i < NUM_REGS; i++)
         begin
            state_ff.work[i] <= CAU_RST_WORK;
         end
         state_ff.shift <= CAU_RST_SHIFT;
         state_ff.rnd <= CAU_RST_RND;
         state_ff.sat <= CAU_RST_SAT;
         state_ff.int_mask <= CAU_RST_MASK;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign wb_dat_o = state_ff.rdata;
   assign wb_ack_o = state_ff.ack;
   assign op_done_o = state_ff.done;
   assign irq_o = |(state_ff.int_stat & state_ff.int_mask);

endmodule

// >>> tb/cau_complex_add_assertions.sv
// Port checker for the complex add unit, bound to its top module
`timescale 1ns/1ps
module cau_complex_add_assertions
   import cau_pkg::*;
#(
   parameter int NUM_REGS = CAU_NUM_REGS
)
(
   input logic clock_i,
   input logic srst_i,
   input logic instr_valid_i,
   input logic [CAU_INSTR_W-1:0] first_instruction_word_i,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_ack_o,
   input logic op_done_o,
   input logic irq_o
);
   // ---------------------------------------------------------------
   // Decode and handshake timing
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   logic [15:0] w;
   logic known;
   assign w = first_instruction_word_i;
   assign known = w == CAU_OPC_ADD_BASE || w == CAU_OPC_ADD_LOAD ||
      w == CAU_OPC_ADD_ALT || w[15:5] == CAU_OPC_SET_SHR;
   base_done_a:
      assert property (instr_valid_i && w == CAU_OPC_ADD_BASE |=> op_done_o)
      else $error("Base add gave no done pulse");
   load_done_a:
      assert property (instr_valid_i && w == CAU_OPC_ADD_LOAD |=> op_done_o)
      else $error("Add with load gave no done pulse");
   alt_done_a:
      assert property (instr_valid_i && w == CAU_OPC_ADD_ALT |=> op_done_o)
      else $error("Second add gave no done pulse");
   shift_done_a:
      assert property (instr_valid_i && w[15:5] == CAU_OPC_SET_SHR
         |=> op_done_o) else $error("Shift setting gave no done pulse");
   unknown_quiet_a:
      assert property (!(instr_valid_i && known) |=> !op_done_o)
      else $error("Done pulse without a decoded instruction");
   ack_answer_a:
      assert property ($rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o)
      else $error("Bus request not answered after one cycle");
   ack_pulse_a:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Bus ack held longer than one cycle");
   ack_idle_a:
      assert property (!wb_stb_i |=> !wb_ack_o)
      else $error("Bus ack without a request");
   base_c: cover property (instr_valid_i && w == CAU_OPC_ADD_BASE);
   load_c: cover property (instr_valid_i && w == CAU_OPC_ADD_LOAD);
   alt_c: cover property (instr_valid_i && w == CAU_OPC_ADD_ALT);
   irq_c: cover property ($rose(irq_o));
endmodule

bind cau_complex_add cau_complex_add_assertions #(.NUM_REGS(NUM_REGS))
   cau_chk_inst (
   .clock_i(clock_i),
   .srst_i(srst_i),
   .instr_valid_i(instr_valid_i),
   .first_instruction_word_i(first_instruction_word_i),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o),
   .op_done_o(op_done_o),
   .irq_o(irq_o)
);

// >>> tb/cau_host_model.sv
// Host pipeline model issuing instructions and memory words
`timescale 1ns/1ps
module cau_host_model
   import cau_pkg::*;
(
   input logic clock_i,
   input logic srst_i,
   input logic go_i,
   input logic [CAU_INSTR_W-1:0] w1_i,
   input logic [CAU_INSTR_W-1:0] w2_i,
   input logic [CAU_DATA_W-1:0] mem_i,
   output logic instr_valid_o,
   output logic [CAU_INSTR_W-1:0] first_o,
   output logic [CAU_INSTR_W-1:0] second_o,
   output logic [CAU_DATA_W-1:0] mem_o
);
   // ---------------------------------------------------------------
   // Issue stage
   // ---------------------------------------------------------------
   logic is_load;
   logic bad_dest;
   assign is_load = w1_i == CAU_OPC_ADD_LOAD;
   assign bad_dest = is_load && w2_i[11:8] inside {CAU_R4, CAU_R5, CAU_R8};
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         instr_valid_o <= 1'b0;
         mem_o <= '0;
      end
      else
      begin
         instr_valid_o <= go_i && !bad_dest;
         // Undriven data bus flips so a stale word is never mistaken
         mem_o <= (go_i && is_load) ? mem_i : ~mem_o;
      end
      first_o <= w1_i;
      second_o <= w2_i;
   end
endmodule

// >>> tb/complex_add_unit_tb.sv
// Self-checking testbench for the complex add unit
`timescale 1ns/1ps
module complex_add_unit_tb
   import cau_pkg::*;
;
   logic clock_i, srst_i, go, valid, cyc, stb, we, ack, done, irq;
   logic [15:0] w1, w2, fw, sw;
   logic [31:0] mem, mw, dat, rdat, got;
   logic [7:0] adr;
   logic [3:0] sel;
   int errors, n_tests;
   logic [31:0] rows [5][8];

   cau_host_model cau_host_model_inst (.clock_i(clock_i), .srst_i(srst_i),
      .go_i(go), .w1_i(w1), .w2_i(w2), .mem_i(mem), .instr_valid_o(valid),
      .first_o(fw), .second_o(sw), .mem_o(mw));
   cau_complex_add cau_complex_add_inst (.clock_i(clock_i), .srst_i(srst_i),
      .instr_valid_i(valid), .first_instruction_word_i(fw),
      .second_instruction_word_i(sw), .memory_word_operand_i(mw),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .op_done_o(done), .irq_o(irq));

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s: expected %h, seen %h", what, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (ack !== 1'b1);
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      // One wait state: ack is seen at the second edge after the raise
      chk("ack cycles", 32'h2, 32'(n));
   endtask

   task automatic rdchk(input string what, input logic [7:0] a,
      input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(what, e, got);
   endtask

   // Writes r5, r4, r3, r2 in that order
   task automatic setq(input logic [31:0] q [4]);
      for (int j = 0; j < 4; j++)
         bus(1'b1, 8'h54 - 8'(4 * j), q[j]);
   endtask

   task automatic issue(input logic [15:0] a, input logic [15:0] b,
      input logic [31:0] m);
      @(posedge clock_i);
      go <= 1'b1;
      w1 <= a;
      w2 <= b;
      mem <= m;
      @(posedge clock_i);
      go <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask

   task automatic irqchk(input logic e);
      @(posedge clock_i);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   // Whole run needs a few hundred cycles
   initial
   begin
      #200000;
      errors++;
      report_and_stop;
   end

   initial
   begin
      srst_i = 1'b1;
      {go, cyc, stb, we, w1, w2, mem, dat, adr, sel} = '0;
      errors = 0;
      n_tests = 0;
      // Config, r5, r4, r3, r2, then expected r5, r4, status
      rows = '{'{32'h0, 32'h1, 32'h2, 32'h3, 32'hFFFF_FFFC,
         32'h4, 32'hFFFF_FFFE, 32'h0},
         '{32'h4, 32'h0, 32'h0, 32'h18, 32'hFFFF_FFE8,
         32'h1, 32'hFFFF_FFFE, 32'h4},
         '{32'h104, 32'h0, 32'h0, 32'h18, 32'hFFFF_FFE8,
         32'h2, 32'hFFFF_FFFF, 32'h104},
         '{32'h0, 32'h7FFF_FFFF, 32'h0, 32'h1, 32'h5,
         32'h8000_0000, 32'h5, 32'h1_0000},
         '{32'h200, 32'h7FFF_FFFF, 32'h8000_0000, 32'h1, 32'hFFFF_FFFF,
         32'h7FFF_FFFF, 32'h8000_0000, 32'h3_0200}};
      repeat (10) @(posedge clock_i);
      srst_i <= 1'b0;
      rdchk("status", CAU_ADR_STATUS, 32'h0);
      rdchk("r5", 8'h54, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b1, CAU_ADR_STATUS, rows[i][0] | 32'h3_0000);
         setq('{rows[i][1], rows[i][2], rows[i][3], rows[i][4]});
         issue(CAU_OPC_ADD_BASE, 16'h0, 32'h0);
         rdchk("r5 sum", 8'h54, rows[i][5]);
         rdchk("r4 sum", 8'h50, rows[i][6]);
         rdchk("flags", CAU_ADR_STATUS, rows[i][7]);
         $display("row %0d done", i);
      end
      bus(1'b1, CAU_ADR_STATUS, 32'h3_0000);
      setq('{32'h7FFF_FFFF, 32'h0, 32'h1, 32'h0});
      issue(CAU_OPC_ADD_BASE, 16'h0, 32'h0);
      bus(1'b1, 8'h4C, 32'h0);
      issue(CAU_OPC_ADD_BASE, 16'h0, 32'h0);
      rdchk("sticky", CAU_ADR_STATUS, 32'h1_0000);
      $display("sticky test done");
      bus(1'b1, 8'h4C, 32'h2);
      issue(CAU_OPC_ADD_LOAD, 16'h0300, 32'h1234_5678);
      rdchk("r5 load", 8'h54, 32'h8000_0002);
      rdchk("r3 load", 8'h4C, 32'h1234_5678);
      issue(16'hE541, 16'h0, 32'h0);
      rdchk("shift", CAU_ADR_STATUS, 32'h1_0001);
      // Clear flags, keep shift 1, and make the real part underflow
      bus(1'b1, CAU_ADR_STATUS, 32'h3_0001);
      bus(1'b1, 8'h5C, 32'h8000_0000);
      issue(CAU_OPC_ADD_ALT, 16'h0, 32'h0);
      rdchk("r7 alt", 8'h5C, 32'h4000_0001);
      rdchk("r6 alt", 8'h58, 32'h0);
      rdchk("alt flag", CAU_ADR_STATUS, 32'h1_0001);
      issue(16'hE503, 16'h0, 32'h0);
      rdchk("r5 kept", 8'h54, 32'h8000_0002);
      $display("load and second add done");
      bus(1'b1, CAU_ADR_INT_MASK, 32'h4);
      irqchk(1'b1);
      bus(1'b1, CAU_ADR_INT_STAT, 32'h7);
      irqchk(1'b0);
      issue(CAU_OPC_ADD_BASE, 16'h0, 32'h0);
      irqchk(1'b1);
      bus(1'b1, CAU_ADR_INT_MASK, 32'h0);
      irqchk(1'b0);
      rdchk("unmapped", 8'h20, 32'h0);
      $display("interrupt and map test done");
      @(posedge clock_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      srst_i <= 1'b0;
      rdchk("r7 reset", 8'h5C, 32'h0);
      rdchk("status reset", CAU_ADR_STATUS, 32'h0);
      irqchk(1'b0);
      $display("reset test done");
      report_and_stop;
   end
endmodule
